/* src/aio_top.sv */
// analog io digital side: switch capture, word format, supply status, wishbone slave
`timescale 1ns/1ps
module aio_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // switches and supply monitor
  input wire aio_pkg::switches_t sw_i,
  input wire logic supply_ok_i,
  // converter side
  input wire logic adc_valid_i,
  input wire logic [1:0] adc_chan_i,
  input wire logic [11:0] adc_data_i,
  output logic [11:0] dac0_o,
  output logic [11:0] dac1_o,
  // indicators
  output logic supply_led_o,
  output logic irq_o
);
  import aio_pkg::*;

  // ---------------------------------------------------------------
  // register map seen by the host
  // ---------------------------------------------------------------
  // 0x00 status: run, unipolar, configuration error, supply good
  // 0x04 event status, a one written clears that bit
  // 0x08 event mask, same layout as event status
  // 0x10..0x1c formatted input words, channels zero to three
  // 0x20, 0x24 output words, upper twelve bits read back
  // 0x30 frozen range setting as one struct
  // 0x34 variant: one for six switches, zero for three
  // all words sit in the low half, upper bits read zero
  // unmapped addresses are acked, writes dropped, reads zero

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b01,  // first enabled cycle after reset
    ST_RUN = 2'b10       // setting frozen
  } phase_t;

  phase_t phase_r, phase_nxt;          // capture phase
  cfg_t cfg_r, cfg_nxt;                // frozen setting
  cfg_t cfg_dec;                       // decoder output
  // variant survives the bus reset like a strap, so the host
  // can pick the three-switch decode before the next capture
  logic six_r = 1'b1;                  // variant select
  logic six_nxt;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
  logic supply_r, supply_nxt;          // previous supply level
  logic [31:0] dat_r, dat_nxt;         // read data
  logic ack_r, ack_nxt;                // bus answer
  logic [11:0] dac0_r, dac0_nxt;
  logic [11:0] dac1_r, dac1_nxt;
  logic led_r, led_nxt;
  logic irq_r, irq_nxt;
  logic pend_r, pend_nxt;              // read waiting for memory
  logic [15:0] in_word;                // formatted converter word
  logic mem_we;                        // memory write strobe
  logic [2:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [2:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic bus_req;                       // new request this cycle
  logic in_mem_rd;                     // read of an input or output word
  logic [IRQ_W-1:0] ev;                // events this cycle
  logic [15:0] host_word;              // written output word

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  switch_decode u_dec (
    .sw_i(sw_i),
    .six_i(six_r),
    .cfg_o(cfg_dec)
  );

  word_store u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ---------------------------------------------------------------
  // input word format
  // ---------------------------------------------------------------
  always_comb begin
    if (cfg_r.unipolar) begin
      // unipolar: sign zero, three zero bits
      in_word = {1'b0, adc_data_i, 3'h0};
    end else begin
      // bipolar: msb sign, four zero bits
      in_word = {adc_data_i, 4'h0};
    end
    // clamp to full scale
    // keeps every word inside plus or minus 32000
    if (cfg_r.unipolar && in_word > FULL_SCALE) begin
      in_word = FULL_SCALE;
    end else if (!cfg_r.unipolar && !in_word[15] && in_word > FULL_SCALE) begin
      in_word = FULL_SCALE;
    end else if (!cfg_r.unipolar && in_word[15] && in_word < NEG_SCALE) begin
      in_word = NEG_SCALE;
    end
  end

  // ---------------------------------------------------------------
  // memory ports: converter writes only, bus reads the store
  // ---------------------------------------------------------------
  always_comb begin
    bus_req = cyc_i && stb_i && !ack_r && !pend_r;
    host_word = dat_i[15:0];
    mem_we = 1'b0;
    mem_waddr = 3'h0;
    mem_wdata = 16'h0;
    // converter writes only; output words live in the dac
    // registers, so the bus never writes the store
    // same format for every channel
    if (adc_valid_i && phase_r == ST_RUN) begin
      mem_we = 1'b1;
      mem_waddr = {1'b0, adc_chan_i};
      mem_wdata = in_word;
    end
    // input words sit in entries zero to three
    mem_raddr = adr_i[5] ? {2'b10, adr_i[2]} : {1'b0, adr_i[3:2]};
    in_mem_rd = (adr_i >= OFF_IN_BASE) && (adr_i < OFF_CONFIG);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    phase_nxt = phase_r;
    cfg_nxt = cfg_r;
    six_nxt = six_r;
    dac0_nxt = dac0_r;
    dac1_nxt = dac1_r;
    dat_nxt = dat_r;
    ack_nxt = 1'b0;
    pend_nxt = 1'b0;
    irq_mask_nxt = irq_mask_r;
    supply_nxt = supply_ok_i;
    ev = '0;
    if (phase_r == ST_CAPTURE) begin
      cfg_nxt = cfg_dec;
      phase_nxt = ST_RUN;
      ev[IRQ_CFG_ERR] = cfg_dec.cfg_err;
    end
    // supply edges; the detector starts at supply good after reset,
    // so a reset with the supply low raises a supply lost event
    ev[IRQ_SUPPLY_LOST] = supply_r && !supply_ok_i;
    ev[IRQ_SUPPLY_BACK] = !supply_r && supply_ok_i;
    irq_stat_nxt = irq_stat_r;
    // bus access
    // a write or register read is acked one cycle after it is
    // taken; an input word read first loads the store address,
    // so its ack comes one cycle later
    // requests are only taken while no ack or read is in
    // flight, which keeps ack a single-cycle pulse
    if (pend_r) begin
      dat_nxt = {16'h0, mem_rdata};
      ack_nxt = 1'b1;
    end else if (bus_req) begin
      if (we_i) begin
        ack_nxt = 1'b1;
        unique case (adr_i)
          OFF_IRQ_STAT: begin
            if (sel_i[0]) begin
              irq_stat_nxt = irq_stat_r & ~dat_i[IRQ_W-1:0];
            end
          end
          OFF_IRQ_MASK: begin
            if (sel_i[0]) begin
              irq_mask_nxt = dat_i[IRQ_W-1:0];
            end
          end
          OFF_OUT_BASE: begin
            if (&sel_i[1:0]) begin
              dac0_nxt = host_word[15:4];
            end
          end
          OFF_OUT_BASE + 8'h04: begin
            if (&sel_i[1:0]) begin
              dac1_nxt = host_word[15:4];
            end
          end
          OFF_CTRL: begin
            if (sel_i[0]) begin
              six_nxt = dat_i[0];
            end
          end
          default: begin
          end
        endcase
      end else if (in_mem_rd && !(adr_i >= OFF_OUT_BASE)) begin
        pend_nxt = 1'b1;
      end else begin
        ack_nxt = 1'b1;
        unique case (adr_i)
          OFF_STATUS: dat_nxt = {28'h0, phase_r == ST_RUN, cfg_r.unipolar,
                                 cfg_r.cfg_err, supply_ok_i};
          OFF_IRQ_STAT: dat_nxt = {29'h0, irq_stat_r};
          OFF_IRQ_MASK: dat_nxt = {29'h0, irq_mask_r};
          OFF_OUT_BASE: dat_nxt = {16'h0, dac0_r, 4'h0};
          OFF_OUT_BASE + 8'h04: dat_nxt = {16'h0, dac1_r, 4'h0};
          OFF_CONFIG: dat_nxt = {22'h0, cfg_r};
          OFF_CTRL: dat_nxt = {31'h0, six_r};
          default: dat_nxt = 32'h0;
        endcase
      end
    end
    // events set after clear so set wins
    irq_stat_nxt = irq_stat_nxt | ev;
    led_nxt = supply_ok_i;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // clock enable low freezes every register; reset still wins
  // variant select is left out of reset on purpose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= ST_CAPTURE;
      cfg_r <= CFG_RESET;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      supply_r <= 1'b1;
      dat_r <= 32'h0;
      ack_r <= 1'b0;
      pend_r <= 1'b0;
      dac0_r <= 12'h0;
      dac1_r <= 12'h0;
      led_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce_i) begin
      phase_r <= phase_nxt;
      cfg_r <= cfg_nxt;
      six_r <= six_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      supply_r <= supply_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      pend_r <= pend_nxt;
      dac0_r <= dac0_nxt;
      dac1_r <= dac1_nxt;
      led_r <= led_nxt;
      irq_r <= irq_nxt;
    end
  end

  // outputs straight from flops
  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign dac0_o = dac0_r;
  assign dac1_o = dac1_r;
  assign supply_led_o = led_r;
  assign irq_o = irq_r;
endmodule

/* src/aio_pkg.sv */
// package: register map, field layouts, reset values and switch decode types
package aio_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;   // config and supply state
  localparam logic [7:0] OFF_IRQ_STAT = 8'h04; // sticky events, write one clears
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08; // interrupt enables
  localparam logic [7:0] OFF_IN_BASE = 8'h10;  // input words 0..3
  localparam logic [7:0] OFF_OUT_BASE = 8'h20; // output words 0..1
  localparam logic [7:0] OFF_CONFIG = 8'h30;   // decoded range setting
  localparam logic [7:0] OFF_CTRL = 8'h34;     // variant select

  // ---------------------------------------------------------------
  // counts and widths
  // ---------------------------------------------------------------
  localparam int N_IN = 4;           // input channels
  localparam int N_OUT = 2;          // output channels
  localparam int CONV_W = 12;        // converter width
  localparam int WORD_W = 16;        // host word width
  localparam int UNI_ZEROS = 3;      // unipolar trailing zeros
  localparam int BI_ZEROS = 4;       // bipolar trailing zeros
  localparam logic [15:0] FULL_SCALE = 16'h7d00;  // 32000
  localparam logic [15:0] NEG_SCALE = 16'h8300;   // -32000

  // ---------------------------------------------------------------
  // irq status bit positions (same layout in mask)
  // ---------------------------------------------------------------
  localparam int IRQ_SUPPLY_LOST = 0;
  localparam int IRQ_SUPPLY_BACK = 1;
  localparam int IRQ_CFG_ERR = 2;
  localparam int IRQ_W = 3;

  // ---------------------------------------------------------------
  // status register field positions
  // ---------------------------------------------------------------
  localparam int ST_SUPPLY_OK = 0;
  localparam int ST_CFG_ERR = 1;
  localparam int ST_UNIPOLAR = 2;
  localparam int ST_SAMPLED = 3;

  // ---------------------------------------------------------------
  // decode enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GAIN_X1 = 2'h0,
    GAIN_X10 = 2'h1,
    GAIN_X100 = 2'h2,
    GAIN_BAD = 2'h3
  } gain_t;

  typedef enum logic [1:0] {
    ATT_NONE = 2'h0,
    ATT_0P8 = 2'h1,
    ATT_0P4 = 2'h2,
    ATT_0P2 = 2'h3
  } atten_t;

  // range index 0..8 naming one full-scale entry, 4'hf = unknown
  localparam logic [3:0] RANGE_BAD = 4'hf;

  // decoded configuration carried as one unit
  typedef struct packed {
    logic unipolar;
    gain_t gain;
    atten_t atten;
    logic [3:0] range;
    logic cfg_err;
  } cfg_t;

  // six switches, bit 0 = switch one
  typedef struct packed {
    logic polarity_switch;
    logic gain_switch_high;
    logic gain_switch_low;
    logic range_switch_three;
    logic range_switch_two;
    logic range_switch_one;
  } switches_t;

  localparam cfg_t CFG_RESET = '{1'b0, GAIN_X1, ATT_NONE, RANGE_BAD, 1'b0};
endpackage

/* src/switch_decode.sv */
// switch bank decoder: range, polarity, gain and attenuation
`timescale 1ns/1ps
module switch_decode (
  // switch levels, 1 = closed
  input wire aio_pkg::switches_t sw_i,
  // variant: 1 = six-switch, 0 = three-switch
  input wire logic six_i,
  // decoded setting
  output aio_pkg::cfg_t cfg_o
);
  import aio_pkg::*;

  logic [2:0] att_sw;  // switches one to three

  // ---------------------------------------------------------------
  // combinational decode
  // ---------------------------------------------------------------
  always_comb begin
    cfg_o = CFG_RESET;
    att_sw = {sw_i.range_switch_three, sw_i.range_switch_two, sw_i.range_switch_one};
    if (six_i) begin
      cfg_o.unipolar = sw_i.polarity_switch;
      unique case ({sw_i.gain_switch_low, sw_i.gain_switch_high})
        2'b00: cfg_o.gain = GAIN_X1;
        2'b01: cfg_o.gain = GAIN_X10;
        2'b10: cfg_o.gain = GAIN_X100;
        2'b11: cfg_o.gain = GAIN_BAD;
      endcase
      unique case (att_sw)
        3'b001: cfg_o.atten = ATT_0P8;
        3'b010: cfg_o.atten = ATT_0P4;
        3'b100: cfg_o.atten = ATT_0P2;
        default: cfg_o.atten = ATT_NONE;
      endcase
      cfg_o.cfg_err = (cfg_o.gain == GAIN_BAD) || (cfg_o.atten == ATT_NONE);
      if (cfg_o.cfg_err) begin
        cfg_o.range = RANGE_BAD;
      end else begin
        // nine gain and attenuation pairs; polarity keeps its own bit
        cfg_o.range = 4'(cfg_o.gain * 3 + cfg_o.atten - 1);
      end
    end else begin
      cfg_o.unipolar = sw_i.range_switch_one;
      unique case ({sw_i.range_switch_two, sw_i.range_switch_three})
        2'b01: cfg_o.range = sw_i.range_switch_one ? 4'h0 : 4'h1;   // 0..10 V / +-5 V
        2'b10: cfg_o.range = sw_i.range_switch_one ? 4'h2 : 4'h3;   // 0..5 V / +-2.5 V
        default: cfg_o.range = RANGE_BAD;
      endcase
      cfg_o.cfg_err = (cfg_o.range == RANGE_BAD);
    end
  end
endmodule

/* src/word_store.sv */
// small word memory with registered read port
`timescale 1ns/1ps
module word_store (
  // clock and enable
  input wire logic clk_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // read port
  input wire logic [2:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:7];  // word storage

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

/* verification/aio_assertions.sv */
// checker: bus timing, supply led, dac load and input word properties
`timescale 1ns/1ps
module aio_assertions import aio_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins
  input wire logic supply_ok_i,
  input wire logic supply_led_o,
  input wire logic [11:0] dac0_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // first cycle of a request
  sequence go_s;
    $rose(cyc_i && stb_i);
  endsequence
  // input word read starts
  sequence in_rd_s;
    go_s ##0 (!we_i && adr_i[7:4] == 4'h1);
  endsequence
  led_follow_a: assert property (!rst_i |=> supply_led_o == $past(supply_ok_i))
    else $error("led does not follow supply");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  write_ack_a: assert property (go_s ##0 we_i |=> ack_o)
    else $error("write not acked next cycle");
  reg_ack_a: assert property (go_s ##0 (!we_i && adr_i[7:4] != 4'h1) |=> ack_o)
    else $error("register read not acked next cycle");
  in_ack_a: assert property (in_rd_s |=> !ack_o ##1 ack_o)
    else $error("input read ack timing wrong");
  in_zero_a: assert property (in_rd_s |=>
    ##1 dat_o[2:0] == 3'h0 && dat_o[31:16] == 16'h0)
    else $error("input word low or upper bits set");
  gap_read_a: assert property (go_s ##0 (!we_i && adr_i == 8'h3c) |=> ack_o && dat_o == 32'h0)
    else $error("unmapped read not zero");
  dac_load_a: assert property (
    go_s ##0 (we_i && adr_i == OFF_OUT_BASE && sel_i[1:0] == 2'h3)
    |-> ##3 dac0_o == $past(dat_i[15:4], 3))
    else $error("dac code not upper twelve bits");
endmodule
bind aio_top aio_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .supply_ok_i(supply_ok_i), .supply_led_o(supply_led_o), .dac0_o(dac0_o));

/* verification/host_model.sv */
// host model: wishbone master cycles and averaged input reads
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_i,
  // wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i
);
  int to_count = 0; // waits that ran out
  initial {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (ack_i !== 1'b1) to_count++;
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
  task automatic avg(input logic [7:0] a, output logic [15:0] m);
    int s;
    logic [31:0] q;
    s = 0;
    for (int i = 0; i < 64; i++) begin
      xfer(1'b0, a, 32'h0, q);
      s += $signed(q[15:0]);
    end
    m = 16'(s / 64);
  endtask
endmodule

/* verification/analog_io_range_and_word_format_tb_top.sv */
// testbench: switch decode, word format, supply events, dac and interrupts
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if (32'(g) !== 32'(e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'(g), 32'(e)); end end
module analog_io_range_and_word_format_tb_top;
  import aio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, led, irq;
  logic [7:0] adr;
  logic [31:0] wd, rd, q;
  switches_t sw = '0;
  logic sup = 1'b1;
  logic av = 1'b0;
  logic [1:0] ach = '0;
  logic [11:0] adat = '0;
  logic [11:0] dac0, dac1;
  logic [15:0] m;
  int fail_count = 0;
  int cmp_count = 0;
  // switch settings and expected {unipolar, gain, atten, cfg_err}
  switches_t sws [4] = '{6'h29, 6'h14, 6'h02, 6'h19};
  logic [5:0] cx [4] = '{6'h32, 6'h0e, 6'h04, 6'h1b};
  logic [11:0] vals [4] = '{12'h123, 12'hfff, 12'h800, 12'h7ff};
  always #5 clk_i = ~clk_i;
  aio_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(rd), .ack_o(ack), .sw_i(sw),
    .supply_ok_i(sup), .adc_valid_i(av), .adc_chan_i(ach), .adc_data_i(adat),
    .dac0_o(dac0), .dac1_o(dac1), .supply_led_o(led), .irq_o(irq));
  host_model i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .dat_o(wd), .dat_i(rd), .ack_i(ack));
  // expected word: left-justified, clamped to full scale
  function automatic logic [15:0] fmt(input logic u, input logic [11:0] d);
    logic signed [16:0] w;
    w = u ? {2'b0, d, 3'b0} : {d[11], d, 4'b0};
    if (w > 17'sd32000) w = 17'sd32000;
    if (w < -17'sd32000) w = -17'sd32000;
    return w[15:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdq(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask
  // power-up with a switch setting, called at time zero or right after an edge
  task automatic boot(input switches_t s);
    sw <= s;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic adc(input logic [1:0] c, input logic [11:0] d);
    @(posedge clk_i);
    av <= 1'b1;
    ach <= c;
    adat <= d;
    @(posedge clk_i);
    av <= 1'b0;
  endtask
  task automatic summarize();
    fail_count += i_host.to_count;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // stop at the first expired wait
  always @(posedge clk_i) if (i_host.to_count != 0) summarize();
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(sws[i]);
      sw <= ~sws[i];
      rdq(OFF_CONFIG);
      `CHK({q[9:5], q[0]}, cx[i])
      `CHK(q[4:1] == RANGE_BAD, cx[i][0])
      rdq(OFF_STATUS);
      `CHK(q[3:0], {1'b1, cx[i][5], cx[i][0], 1'b1})
      for (int j = 0; j < 4; j++) begin
        adc(2'(j), vals[j]);
        rdq(8'(OFF_IN_BASE + 4 * j));
        `CHK(q, fmt(cx[i][5], vals[j]))
      end
    end
    rdq(OFF_IRQ_STAT);
    `CHK(q[IRQ_CFG_ERR], 1'b1)
    `CHK(q[IRQ_SUPPLY_BACK], 1'b0)
    wr(OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(OFF_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    sup <= 1'b0;
    wr(OFF_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk_i);
    `CHK({led, irq}, 2'b01)
    rdq(OFF_STATUS);
    `CHK(q[0], 1'b0)
    wr(OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    sup <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({led, irq}, 2'b11)
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(OFF_OUT_BASE, 32'h8abc);
    wr(8'(OFF_OUT_BASE + 4), 32'h7ff5);
    repeat (2) @(posedge clk_i);
    `CHK({dac0, dac1}, 24'h8ab7ff)
    rdq(8'(OFF_OUT_BASE + 4));
    `CHK(q, 32'h7ff0)
    wr(8'h3c, 32'hffff);
    rdq(8'h3c);
    `CHK(q, 32'h0)
    adc(2'h0, 12'h456);
    i_host.avg(OFF_IN_BASE, m);
    `CHK(m, 16'h4560)
    // three-switch variant, chosen before the next power-up
    wr(OFF_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      boot(switches_t'(i ? 6'h06 : 6'h05));
      rdq(OFF_CTRL);
      `CHK(q, 32'h0)
      rdq(OFF_CONFIG);
      `CHK({q[9], q[4:1] == RANGE_BAD, q[0]}, i ? 3'b011 : 3'b100)
    end
    summarize();
  end
endmodule
